/* src/dsp_core_map.svh */
// Constants of the fixed-point signal processor core: register offsets,
// field positions, vector and shift values, opcode patterns and bus timing.
// Assumes a 100 MHz ref_clk and a 32-bit Avalon-MM slave with byte addresses.
//
// Function
// - 32-bit accumulator from ALU, high and low halves stored separately.
// - ALU takes 16-bit RAM or immediate operand, does arithmetic and Boolean ops.
// - Loaded word shifted left 0 to 15, sign extended, zero filled below.
// - High-half store shifts whole accumulator left 0 to 7 first.
// - Signed 16x16 multiply gives 32-bit product in one cycle.
// - Multiplicand register holds one operand, product register the result.
// - Program memory words can be copied into data RAM.
// - Map pin high maps on-chip ROM; low fetches all words externally.
// - Program counter saved on four-level stack, eight on large variant.
// - Instructions move stack words to and from data RAM.
// - Interrupt request pin is the only interrupt source and can be masked.
// - Port transfers use 16-bit data bus and hold their strobe four cycles.
// - Three-bit port code from instruction drives three low address lines.
// - Conditional branch jumps when the polling pin is low.
// - Without polling pin, branch-on-poll-low never jumps and only skips its address word.
// - Direct address is page bit above seven instruction bits.
// - Indirect address is low byte of selected auxiliary register.
// - Indirect instructions may step auxiliary register and pointer, no extra cycles.
// - Every data-operand instruction accepts indirect mode except immediates.
// - Immediate instructions take operand from the instruction word.
// - Decoder knows shift, store shift, register, mode, address, immediate fields.
// - Most instructions single cycle; only branch, table read and port ops take more.
`ifndef DSP_CORE_MAP_SVH
`define DSP_CORE_MAP_SVH

// Avalon register byte offsets
`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_ACC 6'h08
`define REG_PROD 6'h0C
`define REG_ROM_ADDR 6'h10
`define REG_ROM_DATA 6'h14

// Control and status bit positions
`define CTRL_RUN 0
`define CTRL_INT_EN 1
`define STAT_PC_LSB 0
`define STAT_TOS_LSB 16
`define STAT_INTM 0
`define STAT_PEND 1

// Values
`define INT_VECTOR 16'h0002
`define BUS_WAIT 4'h3
`define STK_MAX 8
`define SHIFT_HIGH 5'h10
`define SHIFT_SUBC 5'h0F

// Byte opcodes (upper instruction byte)
`define OP_ADD 8'b0000_????
`define OP_SUB 8'b0001_????
`define OP_LAC 8'b0010_????
`define OP_SAR 8'b0011_000?
`define OP_LAR 8'b0011_100?
`define OP_IN 8'b0100_0???
`define OP_OUT 8'b0100_1???
`define OP_SACL 8'h50
`define OP_SACH 8'b0101_1???
`define OP_ADDH 8'h60
`define OP_ADDS 8'h61
`define OP_SUBH 8'h62
`define OP_SUBS 8'h63
`define OP_SUBC 8'h64
`define OP_ZALH 8'h65
`define OP_ZALS 8'h66
`define OP_TBLR 8'h67
`define OP_MAR 8'h68
`define OP_LT 8'h6A
`define OP_MPY 8'h6D
`define OP_LDPK 8'h6E
`define OP_LDP 8'h6F
`define OP_LARK 8'b0111_000?
`define OP_XOR 8'h78
`define OP_AND 8'h79
`define OP_OR 8'h7A
`define OP_PUSHD 8'h7B
`define OP_POPD 8'h7D
`define OP_LACK 8'h7E
`define OP_MISC 8'h7F
`define OP_MUL_IMM 8'b100?_????
`define OP_BR_POLL 8'hF6
`define OP_CALL 8'hF8
`define OP_B 8'hF9

// Full-word opcodes of the misc group
`define OP_DINT 16'h7F81
`define OP_EINT 16'h7F82
`define OP_ABS 16'h7F88
`define OP_ZAC 16'h7F89
`define OP_RET 16'h7F8D
`define OP_PAC 16'h7F8E
`define OP_APAC 16'h7F8F
`define OP_SPAC 16'h7F90

`endif

/* src/dsp_core_pkg.sv */
// Types of the signal processor core: instruction layout, states, bus carrier.
// Assumes dsp_core_map.svh supplies the numeric constants.
`default_nettype none
`include "dsp_core_map.svh"

package dsp_core_pkg;

	typedef enum logic [2:0] {
		ST_HALT = 3'b000,
		ST_FETCH = 3'b001,
		ST_RDWAIT = 3'b010,
		ST_EXEC = 3'b011,
		ST_EXEC2 = 3'b100,
		ST_WRWAIT = 3'b101
	} core_state_t;

	typedef enum logic [1:0] {
		K_INSTR = 2'b00,
		K_OPND = 2'b01,
		K_TODM = 2'b10
	} rd_kind_t;

	// Mode byte of a data-operand instruction
	typedef struct packed {
		logic mode;
		logic spare6;
		logic inc;
		logic dec;
		logic keep_ptr;
		logic [1:0] spare2;
		logic nxt_ptr;
	} ind_t;

	typedef struct packed {
		logic [3:0] op4;
		logic [3:0] shift;
		logic mode;
		logic [6:0] daddr;
	} fmt_shift_t;

	typedef struct packed {
		logic [4:0] op5;
		logic [2:0] field3;
		ind_t ind;
	} fmt_field3_t;

	typedef struct packed {
		logic [7:0] op8;
		logic [7:0] imm;
	} fmt_imm_t;

	typedef struct packed {
		logic [2:0] op3;
		logic [12:0] k13;
	} fmt_k13_t;

	typedef union packed {
		fmt_shift_t a;
		fmt_field3_t c;
		fmt_imm_t b;
		fmt_k13_t k;
		logic [15:0] w;
	} instr_t;

	typedef logic [`STK_MAX-1:0][15:0] stk_t;

	// External program and port bus
	typedef struct packed {
		logic [15:0] addr;
		logic prog_rd_n;
		logic io_rd_n;
		logic io_wr_n;
		logic [15:0] dout;
		logic dout_oe;
	} ext_bus_t;

	typedef struct packed {
		core_state_t st;
		rd_kind_t kind;
		logic rom_src;
		logic [3:0] cnt;
		logic [15:0] pc;
		instr_t ir;
		logic [15:0] opnd;
		logic [7:0] dst;
		logic [31:0] acc;
		logic [31:0] preg;
		logic [15:0] treg;
		logic [1:0][15:0] ar;
		logic aux_pointer_select;
		logic dp;
		stk_t stk;
		logic intm;
		logic int_pend;
		logic int_prev;
		ext_bus_t ext;
		logic run;
		logic int_en;
		logic [15:0] rom_wa;
		logic avs_wait;
		logic [31:0] avs_rdata;
		logic [15:0] bus_s1;
		logic [15:0] bus_s2;
		logic poll_s1;
		logic poll_s2;
		logic int_s1;
		logic int_s2;
		logic map_s1;
		logic map_s2;
	} core_t;

endpackage : dsp_core_pkg

`default_nettype wire

/* src/dsp_core_datapath_addressing.sv */
// Fixed-point signal processor core: ALU, shifters, multiplier, addressing,
// return stack, interrupt, polling pin and external program/port bus.
// Assumes one ref_clk domain; pins are synchronised here; Avalon master outside.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_core_map.svh"

module dsp_core_datapath_addressing #(
	parameter int STACK_DEPTH = 4,
	parameter int ROM_WORDS = 4096,
	parameter int DRAM_WORDS = 256,
	parameter bit HAS_POLL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output dsp_core_pkg::ext_bus_t ext_bus,
	input wire logic [15:0] data_bus_in,
	input wire logic poll_input_pin,
	input wire logic int_req_n,
	input wire logic rom_map_select
);
	import dsp_core_pkg::*;

	core_t s;
	core_t n;
	logic [15:0] dram [0:DRAM_WORDS-1];
	logic [15:0] rom [0:ROM_WORDS-1];
	logic dm_we;
	logic [7:0] dm_wa;
	logic [15:0] dm_wd;
	logic rom_we;
	logic [7:0] ea;
	logic [15:0] dm;
	logic [15:0] word_in;
	logic [31:0] diff;
	logic take_int;
	logic [31:0] rd;
	logic [31:0] ctrl_wr;
	logic [31:0] wa_wr;

	// Sign extend and shift a data word left into accumulator alignment
	function automatic logic [31:0] ld_shift(input logic [15:0] w, input logic [4:0] sh);
		ld_shift = {{16{w[15]}}, w} << sh;
	endfunction : ld_shift

	// Shift the full accumulator and keep the upper half
	function automatic logic [15:0] st_shift(input logic [31:0] a, input logic [2:0] sh);
		logic [31:0] t;
		t = a << sh;
		st_shift = t[31:16];
	endfunction : st_shift

	// Signed 16x16 product at full 32-bit width
	function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] ea32;
		logic [31:0] eb32;
		ea32 = {{16{a[15]}}, a};
		eb32 = {{16{b[15]}}, b};
		mul16 = ea32 * eb32;
	endfunction : mul16

	// Push onto the return stack; words below the configured depth are lost
	function automatic stk_t push_f(input stk_t k, input logic [15:0] v);
		for (int i = `STK_MAX - 1; i > 0; i--) begin
			k[i] = (i < STACK_DEPTH) ? k[i-1] : 16'h0000;
		end
		k[0] = v;
		return k;
	endfunction : push_f

	// Pop the return stack, zero enters at the bottom
	function automatic stk_t pop_f(input stk_t k);
		for (int i = 0; i < `STK_MAX - 1; i++) begin
			k[i] = k[i+1];
		end
		k[`STK_MAX-1] = 16'h0000;
		return k;
	endfunction : pop_f

	// Merge Avalon write data under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				o[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return o;
	endfunction : be_merge

	// Start a program or port read; on-chip ROM answers without strobes
	function automatic core_t bus_rd(input core_t c, input logic [15:0] a, input rd_kind_t k,
		input logic io, input logic map_on);
		c.ext.addr = a;
		c.kind = k;
		c.st = ST_RDWAIT;
		c.rom_src = !io && map_on && (32'(a) < ROM_WORDS);
		if (c.rom_src) begin
			c.cnt = 4'h0;
		end else begin
			c.cnt = `BUS_WAIT;
			c.ext.prog_rd_n = io;
			c.ext.io_rd_n = !io;
		end
		return c;
	endfunction : bus_rd

	// Operand address: direct page or indirect auxiliary register
	assign ea = s.ir.c.ind.mode ? s.ar[s.aux_pointer_select][7:0]
		: {s.dp, s.ir.a.daddr};
	assign dm = dram[ea];
	assign word_in = s.rom_src ? rom[s.ext.addr[$clog2(ROM_WORDS)-1:0]] : s.bus_s2;
	assign diff = s.acc - ld_shift(dm, `SHIFT_SUBC);

	// Byte-lane merge of register writes
	assign ctrl_wr = be_merge({30'h0000_0000, s.int_en, s.run}, avs_writedata,
		avs_byteenable);
	assign wa_wr = be_merge({16'h0000, s.rom_wa}, avs_writedata, avs_byteenable);

	// Register read mux
	always_comb begin
		rd = 32'h0000_0000;
		if (avs_address == `REG_CTRL) begin
			rd[`CTRL_RUN] = s.run;
			rd[`CTRL_INT_EN] = s.int_en;
		end else if (avs_address == `REG_STATUS) begin
			rd[`STAT_PC_LSB +: 16] = s.pc;
			rd[`STAT_TOS_LSB +: 16] = s.stk[0];
		end else if (avs_address == `REG_ACC) begin
			rd = s.acc;
		end else if (avs_address == `REG_PROD) begin
			rd = s.preg;
		end else if (avs_address == `REG_ROM_ADDR) begin
			rd[15:0] = s.rom_wa;
		end else if (avs_address == `REG_ROM_DATA) begin
			rd[`STAT_INTM] = s.intm;
			rd[`STAT_PEND] = s.int_pend;
		end
	end

	// Next-state logic of the whole core
	always_comb begin
		n = s;
		dm_we = 1'b0;
		dm_wa = ea;
		dm_wd = 16'h0000;
		rom_we = 1'b0;
		take_int = 1'b0;
		// Pin synchronisers
		n.bus_s1 = data_bus_in;
		n.bus_s2 = s.bus_s1;
		n.poll_s1 = poll_input_pin;
		n.poll_s2 = s.poll_s1;
		n.int_s1 = int_req_n;
		n.int_s2 = s.int_s1;
		n.map_s1 = rom_map_select;
		n.map_s2 = s.map_s1;
		n.int_prev = s.int_s2;
		// Avalon slave: answer one cycle after the request, act when accepted
		if ((avs_read || avs_write) && s.avs_wait) begin
			n.avs_wait = 1'b0;
			n.avs_rdata = avs_read ? rd : 32'h0000_0000;
		end else if (!s.avs_wait) begin
			n.avs_wait = 1'b1;
			if (avs_write) begin
				if (avs_address == `REG_CTRL) begin
					n.run = ctrl_wr[`CTRL_RUN];
					n.int_en = ctrl_wr[`CTRL_INT_EN];
				end else if (avs_address == `REG_ROM_ADDR) begin
					n.rom_wa = wa_wr[15:0];
				end else if (avs_address == `REG_ROM_DATA && avs_byteenable[1:0] == 2'b11) begin
					rom_we = 1'b1;
					n.rom_wa = s.rom_wa + 16'h0001;
				end
			end
		end
		// Core sequencer
		case (s.st)
			ST_HALT: begin
				if (s.run) begin
					n.st = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (!s.run) begin
					n.st = ST_HALT;
				end else if (s.int_pend && !s.intm && s.int_en) begin
					take_int = 1'b1;
					n.stk = push_f(s.stk, s.pc);
					n.pc = `INT_VECTOR;
					n.intm = 1'b1;
				end else begin
					n = bus_rd(n, s.pc, K_INSTR, 1'b0, s.map_s2);
					n.pc = s.pc + 16'h0001;
				end
			end
			ST_RDWAIT: begin
				if (s.cnt != 4'h0) begin
					n.cnt = s.cnt - 4'h1;
				end else begin
					n.ext.prog_rd_n = 1'b1;
					n.ext.io_rd_n = 1'b1;
					n.rom_src = 1'b0;
					case (s.kind)
						K_INSTR: begin
							n.ir = word_in;
							n.st = ST_EXEC;
						end
						K_OPND: begin
							n.opnd = word_in;
							n.st = ST_EXEC2;
						end
						default: begin
							dm_we = 1'b1;
							dm_wa = s.dst;
							dm_wd = word_in;
							n.st = ST_FETCH;
						end
					endcase
				end
			end
			ST_EXEC: begin
				n.st = ST_FETCH;
				// Indirect step of the selected register and pointer, same cycle
				if (s.ir.c.ind.mode && s.ir.b.op8 != `OP_LDPK && s.ir.b.op8 != `OP_LACK &&
					s.ir.b.op8[7:1] != `OP_LARK >> 1 && s.ir.k.op3 != 3'b100 &&
					s.ir.b.op8 != `OP_MISC && s.ir.b.op8[7:4] != 4'hF) begin
					if (s.ir.c.ind.inc) begin
						n.ar[s.aux_pointer_select] =
							s.ar[s.aux_pointer_select] + 16'h0001;
					end else if (s.ir.c.ind.dec) begin
						n.ar[s.aux_pointer_select] =
							s.ar[s.aux_pointer_select] - 16'h0001;
					end
					if (!s.ir.c.ind.keep_ptr) begin
						n.aux_pointer_select = s.ir.c.ind.nxt_ptr;
					end
				end
				// Opcode decode on the field layout of the instruction word
				casez (s.ir.b.op8)
					`OP_ADD: n.acc = s.acc + ld_shift(dm, {1'b0, s.ir.a.shift});
					`OP_SUB: n.acc = s.acc - ld_shift(dm, {1'b0, s.ir.a.shift});
					`OP_LAC: n.acc = ld_shift(dm, {1'b0, s.ir.a.shift});
					`OP_ADDH: n.acc = s.acc + ld_shift(dm, `SHIFT_HIGH);
					`OP_SUBH: n.acc = s.acc - ld_shift(dm, `SHIFT_HIGH);
					`OP_ADDS: n.acc = s.acc + {16'h0000, dm};
					`OP_SUBS: n.acc = s.acc - {16'h0000, dm};
					`OP_SUBC: n.acc = diff[31] ? {s.acc[30:0], 1'b0} : {diff[30:0], 1'b1};
					`OP_ZALH: n.acc = {dm, 16'h0000};
					`OP_ZALS: n.acc = {16'h0000, dm};
					`OP_AND: n.acc = {16'h0000, s.acc[15:0] & dm};
					`OP_OR: n.acc = {s.acc[31:16], s.acc[15:0] | dm};
					`OP_XOR: n.acc = {s.acc[31:16], s.acc[15:0] ^ dm};
					`OP_LACK: n.acc = {24'h00_0000, s.ir.b.imm};
					`OP_SACL: begin
						dm_we = 1'b1;
						dm_wd = s.acc[15:0];
					end
					`OP_SACH: begin
						dm_we = 1'b1;
						dm_wd = st_shift(s.acc, s.ir.c.field3);
					end
					`OP_LAR: n.ar[s.ir.c.field3[0]] = dm;
					`OP_SAR: begin
						dm_we = 1'b1;
						dm_wd = s.ar[s.ir.c.field3[0]];
					end
					`OP_LARK: n.ar[s.ir.c.field3[0]] = {8'h00, s.ir.b.imm};
					`OP_LDPK: n.dp = s.ir.c.ind.nxt_ptr;
					`OP_LDP: n.dp = dm[0];
					`OP_LT: n.treg = dm;
					`OP_MPY: n.preg = mul16(s.treg, dm);
					`OP_MUL_IMM: n.preg = mul16(s.treg, {{3{s.ir.k.k13[12]}}, s.ir.k.k13});
					`OP_PUSHD: n.stk = push_f(s.stk, dm);
					`OP_POPD: begin
						n.stk = pop_f(s.stk);
						dm_we = 1'b1;
						dm_wd = s.stk[0];
					end
					`OP_TBLR: begin
						n.dst = ea;
						n = bus_rd(n, s.acc[15:0], K_TODM, 1'b0, s.map_s2);
					end
					`OP_IN: begin
						n.dst = ea;
						n = bus_rd(n, {13'h0000, s.ir.c.field3}, K_TODM, 1'b1, 1'b0);
					end
					`OP_OUT: begin
						n.ext.addr = {13'h0000, s.ir.c.field3};
						n.ext.dout = dm;
						n.ext.dout_oe = 1'b1;
						n.ext.io_wr_n = 1'b0;
						n.cnt = `BUS_WAIT;
						n.st = ST_WRWAIT;
					end
					`OP_B, `OP_CALL, `OP_BR_POLL: begin
						n = bus_rd(n, s.pc, K_OPND, 1'b0, s.map_s2);
						n.pc = s.pc + 16'h0001;
					end
					`OP_MISC: begin
						if (s.ir.w == `OP_ABS) begin
							n.acc = s.acc[31] ? 32'h0000_0000 - s.acc : s.acc;
						end else if (s.ir.w == `OP_ZAC) begin
							n.acc = 32'h0000_0000;
						end else if (s.ir.w == `OP_PAC) begin
							n.acc = s.preg;
						end else if (s.ir.w == `OP_APAC) begin
							n.acc = s.acc + s.preg;
						end else if (s.ir.w == `OP_SPAC) begin
							n.acc = s.acc - s.preg;
						end else if (s.ir.w == `OP_EINT) begin
							n.intm = 1'b0;
						end else if (s.ir.w == `OP_DINT) begin
							n.intm = 1'b1;
						end else if (s.ir.w == `OP_RET) begin
							n.pc = s.stk[0];
							n.stk = pop_f(s.stk);
						end
					end
					default: begin
					end
				endcase
			end
			ST_EXEC2: begin
				n.st = ST_FETCH;
				if (s.ir.b.op8 == `OP_B) begin
					n.pc = s.opnd;
				end else if (s.ir.b.op8 == `OP_CALL) begin
					n.stk = push_f(s.stk, s.pc);
					n.pc = s.opnd;
				end else if (HAS_POLL && !s.poll_s2) begin
					n.pc = s.opnd;
				end
			end
			ST_WRWAIT: begin
				if (s.cnt != 4'h0) begin
					n.cnt = s.cnt - 4'h1;
				end else begin
					n.ext.io_wr_n = 1'b1;
					n.ext.dout_oe = 1'b0;
					n.st = ST_FETCH;
				end
			end
			default: n.st = ST_HALT;
		endcase
		// Falling request edge sets pending; a new edge wins over the taking clear
		n.int_pend = (s.int_pend && !take_int) || (s.int_prev && !s.int_s2);
	end

	// State register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.ext.prog_rd_n <= 1'b1;
			s.ext.io_rd_n <= 1'b1;
			s.ext.io_wr_n <= 1'b1;
			s.avs_wait <= 1'b1;
			s.intm <= 1'b1;
			s.int_s1 <= 1'b1;
			s.int_s2 <= 1'b1;
			s.int_prev <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Data RAM and on-chip program store writes
	always_ff @(posedge ref_clk) begin
		if (dm_we) begin
			dram[dm_wa] <= dm_wd;
		end
		if (rom_we) begin
			rom[s.rom_wa[$clog2(ROM_WORDS)-1:0]] <= avs_writedata[15:0];
		end
	end

	assign avs_readdata = s.avs_rdata;
	assign avs_waitrequest = s.avs_wait;
	assign ext_bus = s.ext;

endmodule : dsp_core_datapath_addressing

`default_nettype wire

/* verification/dsp_core_datapath_addressing_sva.sv */
// Checker of the signal processor core: register bus handshake and external strobes.
// Assumes it is bound to the core and sees only the core's ports.
`timescale 1ns/100ps
`default_nettype none

module dsp_core_datapath_addressing_sva import dsp_core_pkg::*; #(
	parameter int ROM_WORDS = 4096
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire dsp_core_pkg::ext_bus_t ext_bus,
	input wire logic rom_map_select
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Register bus answers after exactly one wait state
	a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("register request not answered in one cycle");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("accept cycle longer than one cycle");
	a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 6'h14
		|=> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!avs_waitrequest ##1 !(avs_read || avs_write)
		|-> $stable(avs_readdata)) else $error("read data changed while idle");
	// External strobes last four cycles
	a_fetch_four: assert property ($fell(ext_bus.prog_rd_n) |->
		!ext_bus.prog_rd_n [*4] ##1 ext_bus.prog_rd_n) else $error("fetch strobe length");
	a_port_read_four: assert property ($fell(ext_bus.io_rd_n) |->
		!ext_bus.io_rd_n [*4] ##1 ext_bus.io_rd_n) else $error("port read strobe length");
	a_port_write_four: assert property ($fell(ext_bus.io_wr_n) |->
		(!ext_bus.io_wr_n && ext_bus.dout_oe) [*4] ##1 (ext_bus.io_wr_n && !ext_bus.dout_oe))
		else $error("port write strobe length");
	a_port_code_held: assert property ($fell(ext_bus.io_rd_n) || $fell(ext_bus.io_wr_n) |=>
		$stable(ext_bus.addr) [*3]) else $error("port address moved in transfer");
	a_one_strobe: assert property ($onehot0(~{ext_bus.prog_rd_n,
		ext_bus.io_rd_n, ext_bus.io_wr_n})) else $error("two strobes low together");
	a_drive_only_write: assert property (ext_bus.dout_oe |-> !ext_bus.io_wr_n)
		else $error("data driven outside port write");
	a_rom_no_strobe: assert property (!ext_bus.prog_rd_n |->
		!rom_map_select || ext_bus.addr >= ROM_WORDS) else $error("on-chip word fetched outside");
endmodule : dsp_core_datapath_addressing_sva

`default_nettype wire

/* verification/ext_mem_io_model.sv */
// Model of external program memory and port devices on the 16-bit bus.
// Assumes the core's registered strobes; released bus toggles every cycle.
`timescale 1ns/100ps
`default_nettype none

module ext_mem_io_model import dsp_core_pkg::*; (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire dsp_core_pkg::ext_bus_t ext_bus,
	output logic [15:0] data_bus_in,
	output logic [2:0] out_port,
	output logic [15:0] out_data
);
	localparam logic [15:0] PROG [8] = '{16'h7020, 16'h4520, 16'h4621, 16'h20A0,
		16'h4B80, 16'hF600, 16'h0005, 16'h0000};
	logic [15:0] last_r;

	// Bus level from all drivers; port value carries the decoded port code
	always_comb begin
		if (ext_bus.dout_oe) begin
			data_bus_in = ext_bus.dout;
		end else if (!ext_bus.prog_rd_n) begin
			data_bus_in = PROG[ext_bus.addr[2:0]];
		end else if (!ext_bus.io_rd_n) begin
			data_bus_in = {13'h14B8, ext_bus.addr[2:0]};
		end else begin
			data_bus_in = ~last_r;
		end
	end

	// Port write capture and idle pattern
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			last_r <= 16'h0000;
			out_port <= 3'h0;
			out_data <= 16'h0000;
		end else begin
			last_r <= data_bus_in;
			if (!ext_bus.io_wr_n && ext_bus.dout_oe) begin
				out_port <= ext_bus.addr[2:0];
				out_data <= ext_bus.dout;
			end
		end
	end
endmodule : ext_mem_io_model

`default_nettype wire

/* verification/dsp_core_datapath_addressing_test.sv */
// Testbench of the signal processor core: on-chip and external program runs.
// Assumes the checker and the external memory model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "dsp_core_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end

module dsp_core_datapath_addressing_test import dsp_core_pkg::*;;
	localparam logic [15:0] ROM_PROG [12] = '{16'h7E81, 16'h5010, 16'h2F10, 16'h5C12,
		16'h6A10, 16'h9FFD, 16'h7F8E, 16'h5011, 16'h6512, 16'h0111, 16'hF900, 16'h000A};
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rom_map_select = 1'b1;
	logic poll_pin = 1'b1;
	logic int_n = 1'b1;
	ext_bus_t ext_bus;
	logic [15:0] data_bus_in;
	logic [2:0] out_port;
	logic [15:0] out_data;
	logic [31:0] rd;
	int error_cnt = 0;
	int compares = 0;

	// Clock of 10 ns period
	always #5 ref_clk = ~ref_clk;

	dsp_core_datapath_addressing #(.ROM_WORDS(64)) u_dsp_core_datapath_addressing (
		.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_bus(ext_bus), .data_bus_in(data_bus_in),
		.poll_input_pin(poll_pin), .int_req_n(int_n), .rom_map_select(rom_map_select));

	ext_mem_io_model u_ext_mem_io_model (
		.ref_clk(ref_clk), .resetn(resetn), .ext_bus(ext_bus), .data_bus_in(data_bus_in),
		.out_port(out_port), .out_data(out_data));

	// One register access, held until waitrequest is sampled low
	task automatic bus_req(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			$display("Error at %0t: register access not answered", $time);
		end
	endtask : bus_req

	// Reset with the map pin driven to the given level, held for two cycles
	task automatic do_reset(input logic map);
		resetn <= 1'b0;
		rom_map_select <= map;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
	endtask : do_reset

	// Poll the program counter until it reaches the target
	task automatic wait_pc(input logic [15:0] pc);
		int n;
		n = 0;
		do begin
			bus_req(1'b0, `REG_STATUS, 32'h0000_0000);
			n++;
		end while (rd[15:0] < pc && n < 200);
	endtask : wait_pc

	task automatic print_verdict;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		do_reset(1'b1);
		bus_req(1'b0, 6'h3C, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
		bus_req(1'b1, 6'h3C, 32'hFFFF_FFFF);
		bus_req(1'b0, 6'h3C, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
		$display("test unmapped done");
		bus_req(1'b1, `REG_ROM_ADDR, 32'h0000_0000);
		for (int i = 0; i < 12; i++) begin
			bus_req(1'b1, `REG_ROM_DATA, {16'h0000, ROM_PROG[i]});
		end
		bus_req(1'b1, `REG_CTRL, 32'h0000_0001);
		wait_pc(16'h000A);
		bus_req(1'b0, `REG_ACC, 32'h0000_0000);
		`CHK(rd, 32'h0407_FCFA)
		bus_req(1'b0, `REG_PROD, 32'h0000_0000);
		`CHK(rd, 32'hFFFF_FE7D)
		$display("test on-chip program done");
		poll_pin <= 1'b0;
		do_reset(1'b0);
		bus_req(1'b1, `REG_CTRL, 32'h0000_0001);
		wait_pc(16'h0006);
		bus_req(1'b0, `REG_ACC, 32'h0000_0000);
		`CHK(rd, 32'hFFFF_A5C5)
		`CHK(out_port, 3'h3)
		`CHK(out_data, 16'hA5C6)
		int_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		int_n <= 1'b1;
		bus_req(1'b0, `REG_ROM_DATA, 32'h0000_0000);
		`CHK(rd[1:0], 2'b11)
		bus_req(1'b0, `REG_STATUS, 32'h0000_0000);
		`CHK(rd[15:0] >= 16'h0005 && rd[15:0] <= 16'h0007, 1'b1)
		$display("test external program done");
		print_verdict();
	end

	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule : dsp_core_datapath_addressing_test

bind dsp_core_datapath_addressing dsp_core_datapath_addressing_sva #(
	.ROM_WORDS(ROM_WORDS)
) u_dsp_core_datapath_addressing_sva (
	.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ext_bus(ext_bus), .rom_map_select(rom_map_select));

`default_nettype wire
